// [src/sdwm_pkg.sv]
/*
 * Constants shared by the supply droop wake monitor: timing counts at the
 * 25 MHz ref_clk, droop ratio, and the period thresholds for the enable pin.
 * Assumes a 25 MHz clock and an external ADC-style supply level input.
 */
package sdwm_pkg;

   // ----------------------------------------------------------------------
   // Clock
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_HZ = 25_000_000;

   // ----------------------------------------------------------------------
   // Times in their own units
   // ----------------------------------------------------------------------
   localparam int unsigned ARM_QUAL_NS     = 500;
   localparam int unsigned WAKE_PULSE_NS   = 1_000;
   localparam int unsigned WAKE_RATE_HZ    = 33_000;
   localparam int unsigned DIS_PERIOD_US   = 177;
   localparam int unsigned EN_PERIOD_US    = 57;

   // ----------------------------------------------------------------------
   // Cycle counts
   // ----------------------------------------------------------------------
   // Least time: strictly longer than 500 ns, so one count past the rounded-up value
   localparam int unsigned ARM_QUAL_CYC   = (ARM_QUAL_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
   localparam int unsigned WAKE_PULSE_CYC = WAKE_PULSE_NS * (CLK_HZ / 1_000_000) / 1_000;
   localparam int unsigned WAKE_REP_CYC   = CLK_HZ / WAKE_RATE_HZ;
   localparam int unsigned DIS_PERIOD_CYC = DIS_PERIOD_US * (CLK_HZ / 1_000_000);
   localparam int unsigned EN_PERIOD_CYC  = EN_PERIOD_US * (CLK_HZ / 1_000_000);

   localparam int unsigned DIS_RUN_COUNT  = 63;
   localparam int unsigned EN_CUM_COUNT   = 32;

   // ----------------------------------------------------------------------
   // Widths and droop ratio (trip when level*100 <= ref*97)
   // ----------------------------------------------------------------------
   localparam int unsigned LVL_W      = 12;
   localparam int unsigned PER_W      = 13;
   localparam int unsigned TMR_W      = 10;
   localparam int unsigned CNT_W      = 6;
   localparam int unsigned DROOP_NUM  = 97;
   localparam int unsigned DROOP_DEN  = 100;

endpackage : sdwm_pkg

// [src/sdwm_monitor.sv]
/*
 * Digital core of the supply droop wake monitor: cycle detection on the
 * winding comparator, reference sampling, wake pulse drive and the open-drain
 * secondary enable output.
 * Assumes synchronous inputs, resetn driven low by supply undervoltage lockout,
 * and a supply level word from an external converter.
 */
`timescale 1ns/100ps

// How it works
// [RL1] Each detected power cycle captures the supply level as new droop reference.
// [RL2] Supply at or below 97 percent of reference switches wake into output mode.
// [RL3] Reset from undervoltage lockout holds all state inactive.
// [RL4] Arm detection after wake stays below threshold longer than 500 ns.
// [RL5] Armed rise gives one detect pulse: restart oscillator, count, sample.
// [RL6] Wake output drives 1 us pulses at 33 kHz until a cycle is detected.
// [RL7] Enable pulled low after 63 consecutive periods longer than 177 us.
// [RL8] Enable released after 32 cumulative periods shorter than 57 us.
// [RL9] Controller delivers power cycles no more than 40 ms apart.
// [RL10] Period is detect-to-detect; long run clears on shorter, short count on toggle.
module sdwm_monitor (
   // Clock and lockout reset
   input  wire logic                       ref_clk,
   input  wire logic                       resetn,
   // Winding comparator and supply level
   input  wire logic                       wake_above_thr,
   input  wire logic [sdwm_pkg::LVL_W-1:0] supply_level,
   // Wake pin drive
   output logic                            wake_oe,
   output logic                            wake_out,
   // Open-drain secondary enable
   output logic                            secondary_enable_out_oe,
   output logic                            secondary_enable_out,
   // Status
   output logic                            power_cycle_detect,
   output logic [sdwm_pkg::LVL_W-1:0]      ref_level,
   output logic                            wake_mode
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   logic                        armed_ff,   nxt_armed;
   logic [sdwm_pkg::TMR_W-1:0]  qual_ff,    nxt_qual;
   logic                        pcd_ff,     nxt_pcd;
   logic [sdwm_pkg::LVL_W-1:0]  ref_ff,     nxt_ref;
   logic                        ref_vld_ff, nxt_ref_vld;
   logic                        wmode_ff,   nxt_wmode;
   logic [sdwm_pkg::TMR_W-1:0]  osc_ff,     nxt_osc;
   logic                        wdrv_ff,    nxt_wdrv;
   logic [sdwm_pkg::PER_W-1:0]  per_ff,     nxt_per;
   logic [sdwm_pkg::CNT_W-1:0]  long_ff,    nxt_long;
   logic [sdwm_pkg::CNT_W-1:0]  short_ff,   nxt_short;
   logic                        dis_ff,     nxt_dis;
   logic [7:0]                  pcd_cnt_ff, nxt_pcd_cnt;

   logic                        droop;
   logic                        det;
   logic                        per_long;
   logic                        per_short;

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb
   begin
      nxt_armed   = armed_ff;
      nxt_qual    = qual_ff;
      nxt_ref     = ref_ff;
      nxt_ref_vld = ref_vld_ff;
      nxt_wmode   = wmode_ff;
      nxt_osc     = osc_ff;
      nxt_wdrv    = 1'b0;
      nxt_long    = long_ff;
      nxt_short   = short_ff;
      nxt_dis     = dis_ff;
      nxt_pcd_cnt = pcd_cnt_ff;

      // Comparator ignored while we drive the pin ourselves
      det = armed_ff && wake_above_thr && !wdrv_ff;  // RL5
      nxt_pcd = det;                                 // RL5

      // Arming qualification
      if (wake_above_thr || wdrv_ff)
      begin
         nxt_qual = '0;
      end
      else if (qual_ff <= sdwm_pkg::TMR_W'(sdwm_pkg::ARM_QUAL_CYC))
      begin
         nxt_qual = qual_ff + 1'b1;
      end
      if (det)
      begin
         nxt_armed = 1'b0;                           // RL5
      end
      else if (qual_ff > sdwm_pkg::TMR_W'(sdwm_pkg::ARM_QUAL_CYC))
      begin
         nxt_armed = 1'b1;                           // RL4
      end

      // Sampling and droop comparison
      droop = ref_vld_ff && ((32'(supply_level) * sdwm_pkg::DROOP_DEN)
              <= (32'(ref_ff) * sdwm_pkg::DROOP_NUM));         // RL2
      if (det)
      begin
         nxt_ref     = supply_level;                 // RL1
         nxt_ref_vld = 1'b1;
         nxt_wmode   = 1'b0;                         // RL6
         nxt_osc     = '0;                           // RL5
         if (pcd_cnt_ff != '1)
         begin
            nxt_pcd_cnt = pcd_cnt_ff + 1'b1;         // RL5
         end
      end
      else
      begin
         if (droop)
         begin
            nxt_wmode = 1'b1;                        // RL2
         end
         // Entering wake mode restarts the oscillator so the first pulse is full length
         if (droop && !wmode_ff)
         begin
            nxt_osc = '0;                            // RL6
         end
         else if (osc_ff == sdwm_pkg::TMR_W'(sdwm_pkg::WAKE_REP_CYC - 1))
         begin
            nxt_osc = '0;
         end
         else
         begin
            nxt_osc = osc_ff + 1'b1;
         end
      end

      // Wake pulse: first 1 us of each oscillator period
      if (!det && (wmode_ff || droop)
          && nxt_osc < sdwm_pkg::TMR_W'(sdwm_pkg::WAKE_PULSE_CYC))
      begin
         nxt_wdrv = 1'b1;                            // RL6
      end

      // Switching period measurement
      if (det)
      begin
         nxt_per = '0;                               // RL10
      end
      else if (per_ff != '1)
      begin
         nxt_per = per_ff + 1'b1;
      end
      else
      begin
         nxt_per = per_ff;
      end
      // At a detect the counter holds the period minus one
      per_long  = per_ff >= sdwm_pkg::PER_W'(sdwm_pkg::DIS_PERIOD_CYC);      // RL7
      per_short = per_ff < sdwm_pkg::PER_W'(sdwm_pkg::EN_PERIOD_CYC - 1);    // RL8

      if (det && pcd_cnt_ff != '0)
      begin
         if (per_long)
         begin
            nxt_long = long_ff + 1'b1;               // RL7
         end
         else
         begin
            nxt_long = '0;                           // RL10
         end
         if (per_short && dis_ff)
         begin
            nxt_short = short_ff + 1'b1;             // RL8
         end
         if (!dis_ff && per_long
             && long_ff == sdwm_pkg::CNT_W'(sdwm_pkg::DIS_RUN_COUNT - 1))
         begin
            nxt_dis   = 1'b1;                        // RL7
            nxt_long  = '0;
            nxt_short = '0;                          // RL10
         end
         else if (dis_ff && per_short
                  && short_ff == sdwm_pkg::CNT_W'(sdwm_pkg::EN_CUM_COUNT - 1))
         begin
            nxt_dis   = 1'b0;                        // RL8
            nxt_long  = '0;
            nxt_short = '0;                          // RL10
         end
      end
   end

   // ----------------------------------------------------------------------
   // Registers, cleared while the supply is in lockout
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         armed_ff   <= 1'b0;                         // RL3
         qual_ff    <= '0;
         pcd_ff     <= 1'b0;
         ref_ff     <= '0;
         ref_vld_ff <= 1'b0;
         wmode_ff   <= 1'b0;
         osc_ff     <= '0;
         wdrv_ff    <= 1'b0;
         per_ff     <= '0;
         long_ff    <= '0;
         short_ff   <= '0;
         dis_ff     <= 1'b0;
         pcd_cnt_ff <= '0;
      end
      else
      begin
         armed_ff   <= nxt_armed;
         qual_ff    <= nxt_qual;
         pcd_ff     <= nxt_pcd;
         ref_ff     <= nxt_ref;
         ref_vld_ff <= nxt_ref_vld;
         wmode_ff   <= nxt_wmode;
         osc_ff     <= nxt_osc;
         wdrv_ff    <= nxt_wdrv;
         per_ff     <= nxt_per;
         long_ff    <= nxt_long;
         short_ff   <= nxt_short;
         dis_ff     <= nxt_dis;
         pcd_cnt_ff <= nxt_pcd_cnt;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign wake_oe                 = wdrv_ff;
   assign wake_out                = wdrv_ff;
   assign secondary_enable_out_oe = dis_ff;          // RL7
   assign secondary_enable_out    = 1'b0;
   assign power_cycle_detect      = pcd_ff;
   assign ref_level               = ref_ff;
   assign wake_mode               = wmode_ff;

endmodule : sdwm_monitor

// [testbench/sdwm_checker.sv]
/* Port assertions for sdwm_monitor.
   Assumes binding onto sdwm_monitor, one clock ref_clk. */
`timescale 1ns/100ps
module sdwm_checker (
   // Clock and reset
   input wire logic                       ref_clk,
   input wire logic                       resetn,
   // Inputs
   input wire logic                       wake_above_thr,
   input wire logic [sdwm_pkg::LVL_W-1:0] supply_level,
   // Outputs
   input wire logic                       wake_oe,
   input wire logic                       wake_out,
   input wire logic                       secondary_enable_out_oe,
   input wire logic                       secondary_enable_out,
   input wire logic                       power_cycle_detect,
   input wire logic [sdwm_pkg::LVL_W-1:0] ref_level,
   input wire logic                       wake_mode
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Length of the current wake pulse
   logic [7:0] run_ff;
   logic [7:0] nxt_run;
   always_comb nxt_run = wake_oe ? run_ff + 8'h01 : 8'h00;
   always_ff @(posedge ref_clk) run_ff <= resetn ? nxt_run : 8'h00;
   // Quiet run on the comparator, and whether a full arm time passed since the last detect
   logic [7:0] low_ff;
   logic [7:0] nxt_low;
   logic       qual_ff;
   logic       nxt_qual;
   always_comb nxt_low = (wake_above_thr || wake_oe) ? 8'h00
                         : ((low_ff == 8'hff) ? low_ff : low_ff + 8'h01);
   always_comb nxt_qual = !power_cycle_detect
                          && (qual_ff || low_ff >= 8'(sdwm_pkg::ARM_QUAL_CYC));
   always_ff @(posedge ref_clk) low_ff <= resetn ? nxt_low : 8'h00;
   always_ff @(posedge ref_clk) qual_ff <= resetn && nxt_qual;
   sequence det_s;
      $past(wake_above_thr) && !$past(wake_oe) ##0 power_cycle_detect;
   endsequence
   AST_RESET_QUIET: assert property (disable iff (1'b0) !resetn |=>
      !power_cycle_detect && !wake_oe && !wake_mode && !secondary_enable_out_oe && ref_level == '0)
      else $error("state not cleared by reset");
   AST_DETECT_SINGLE: assert property (power_cycle_detect |=> !power_cycle_detect)
      else $error("detect pulse longer than one cycle");
   AST_DETECT_CAUSE: assert property (power_cycle_detect |-> det_s)
      else $error("detect without unmasked rise");
   AST_REF_CAPTURE: assert property (power_cycle_detect |-> ref_level == $past(supply_level))
      else $error("reference not captured at detect");
   AST_REF_HOLD: assert property (!power_cycle_detect |-> $stable(ref_level))
      else $error("reference changed without detect");
   AST_PULSE_WIDTH: assert property ($fell(wake_oe) && $past(resetn) |-> run_ff == 8'd25)
      else $error("wake pulse width wrong");
   AST_OE_IN_WAKE: assert property (wake_oe |-> wake_mode && wake_out)
      else $error("wake drive outside wake mode");
   AST_WAKE_CAUSE: assert property ($rose(wake_mode) |->
      $past(supply_level) * 100 <= $past(ref_level) * 97) else $error("wake without droop");
   AST_WAKE_EXIT: assert property (power_cycle_detect |=> !wake_mode)
      else $error("wake mode kept after detect");
   AST_ENS_LOW: assert property (secondary_enable_out == 1'b0)
      else $error("enable drive value not low");
   AST_ARM_QUAL: assert property (power_cycle_detect |-> $past(qual_ff))
      else $error("detect without a full quiet time before it");
   AST_ENS_AT_DETECT: assert property ($changed(secondary_enable_out_oe) |-> power_cycle_detect)
      else $error("enable output moved outside a detect");
endmodule : sdwm_checker

bind sdwm_monitor sdwm_checker chk (.ref_clk(ref_clk), .resetn(resetn),
   .wake_above_thr(wake_above_thr), .supply_level(supply_level), .wake_oe(wake_oe),
   .wake_out(wake_out), .secondary_enable_out_oe(secondary_enable_out_oe),
   .secondary_enable_out(secondary_enable_out), .power_cycle_detect(power_cycle_detect),
   .ref_level(ref_level), .wake_mode(wake_mode));

// [testbench/sdwm_primary_model.sv]
/* Primary-side controller model: holds the winding low for a requested
   span, then lets it rise to mark a power cycle.
   Assumes go and low_cyc change at the falling edge. */
`timescale 1ns/100ps
module sdwm_primary_model (
   // Clock
   input wire logic       ref_clk,
   // Request
   input wire logic       go,
   input wire logic [7:0] low_cyc,
   // Winding comparator
   output logic           wake_above_thr
);
   logic [7:0] low_ff = 8'h00;
   always @(negedge ref_clk)
      low_ff <= go ? low_cyc : (low_ff != 8'h00 ? low_ff - 8'h01 : 8'h00);
   assign wake_above_thr = (low_ff == 8'h00);
endmodule : sdwm_primary_model

// [testbench/tb_top.sv]
/* Self-checking bench for sdwm_monitor with a primary-side model.
   Assumes a 25 MHz clock and the package timing constants. */
`timescale 1ns/100ps
module tb_top;
   logic        ref_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        go = 1'b0;
   logic [7:0]  low_cyc = 8'h00;
   logic [11:0] supply_level = 12'h000;
   logic        above, wake_oe, wake_out, en_oe, en_val, det, wake_mode;
   logic [11:0] ref_level;
   int          fail_count = 0;
   int          checks_done = 0;
   int          det_seen = 0;
   int          exp_det = 0;
   int          exp_ref = 0;
   int          hi_cyc, i;
   integer      seed = 32'hc17f;
   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) det_seen <= det_seen + ((det === 1'b1) ? 1 : 0);
   sdwm_primary_model model (.ref_clk(ref_clk), .go(go), .low_cyc(low_cyc),
      .wake_above_thr(above));
   sdwm_monitor uut (.ref_clk(ref_clk), .resetn(resetn), .wake_above_thr(above),
      .supply_level(supply_level), .wake_oe(wake_oe), .wake_out(wake_out),
      .secondary_enable_out_oe(en_oe), .secondary_enable_out(en_val),
      .power_cycle_detect(det), .ref_level(ref_level), .wake_mode(wake_mode));
   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   task chk_sig(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      if (got !== exp)
         fail_count++;
   endtask : chk_sig
   task chk_cnt(input int got, input int exp);
      checks_done++;
      if (got != exp)
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      if (got != exp)
         fail_count++;
   endtask : chk_cnt
   task cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task cycle_req(input logic [7:0] n);
      go <= 1'b1;
      low_cyc <= n;
      @(negedge ref_clk);
      go <= 1'b0;
      cyc(n + 6);
      if (n > sdwm_pkg::ARM_QUAL_CYC)
      begin
         exp_det++;
         exp_ref = supply_level;
      end
      chk_cnt(det_seen, exp_det);
      chk_sig(ref_level, exp_ref[11:0]);
   endtask : cycle_req
   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   // ----------------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------------
   initial
   begin
      #800_000;
      fail_count++;
      finish_test;
   end
   initial
   begin
      cyc(12);
      chk_sig({wake_oe, en_oe, det, wake_mode, ref_level}, 12'h000);
      resetn = 1'b1;
      for (i = 0; i < 12; i++)
      begin
         // Kept within 3 percent so no droop masks the quiet window
         supply_level = 12'h800 + 12'($random(seed) & 32'h1f);
         cycle_req((i % 3 == 0) ? 8'd12 : 8'd16);
      end
      supply_level = 12'((exp_ref * 97) / 100 + 1);
      cyc(4);
      chk_sig(wake_mode, 1'b0);
      supply_level = 12'((exp_ref * 97) / 100);
      cyc(3);
      chk_sig(wake_mode, 1'b1);
      // Align to the start of a pulse, then count two full oscillator periods
      for (i = 0; i < 100 && wake_oe === 1'b1; i++) @(negedge ref_clk);
      for (i = 0; i < 800 && wake_oe !== 1'b1; i++) @(negedge ref_clk);
      hi_cyc = 0;
      repeat (2 * sdwm_pkg::WAKE_REP_CYC)
      begin
         hi_cyc += (wake_oe === 1'b1) ? 1 : 0;
         @(negedge ref_clk);
      end
      chk_cnt(hi_cyc, int'(2 * sdwm_pkg::WAKE_PULSE_CYC));
      for (i = 0; i < 100 && wake_oe !== 1'b0; i++) @(negedge ref_clk);
      supply_level = 12'h400 + 12'($random(seed) & 32'h3ff);
      cycle_req(8'd16);
      chk_sig(wake_mode, 1'b0);
      resetn = 1'b0;
      supply_level = 12'h000;
      cyc(2);
      chk_sig({wake_oe, en_oe, wake_mode, ref_level}, 12'h000);
      resetn = 1'b1;
      exp_ref = 0;
      cyc(20);
      chk_sig(wake_mode, 1'b0);
      supply_level = 12'h800 + 12'($random(seed) & 32'h1f);
      cycle_req(8'd16);
      chk_sig({en_val, en_oe}, 2'b00);
      finish_test;
   end
endmodule : tb_top
